// >>> core/pps_pkg.sv
// Constants, types and address map of the parallel port register bank
package pps_pkg;

  // ==========================================================================
  // Address map
  localparam logic [19:0] PPS_SFR_FIRST = 20'h00000;
  localparam logic [19:0] PPS_SFR_LAST  = 20'h0003F;
  localparam logic [19:0] PPS_DBR_FIRST = 20'h00F00;
  localparam logic [19:0] PPS_DBR_LAST  = 20'h00FFF;
  localparam int          PPS_DBR_AW    = 8;

  // ==========================================================================
  // Register offsets inside the special function area
  localparam logic [5:0] OFF_PORT_ZERO_LATCH = 6'h00;
  localparam logic [5:0] OFF_PORT_ONE        = 6'h01;
  localparam logic [5:0] OFF_PORT_TWO        = 6'h02;
  localparam logic [5:0] OFF_PORT_FOUR       = 6'h04;
  localparam logic [5:0] OFF_PORT_FIVE       = 6'h05;
  localparam logic [5:0] OFF_PORT_SIX        = 6'h06;
  localparam logic [5:0] OFF_PORT_SEVEN      = 6'h07;
  localparam logic [5:0] OFF_PORT_EIGHT      = 6'h08;
  localparam logic [5:0] OFF_PORT_NINE       = 6'h09;
  localparam logic [5:0] OFF_PORT_ONE_DIR    = 6'h0B;
  localparam logic [5:0] OFF_PORT_FOUR_DIR   = 6'h0C;
  localparam logic [5:0] OFF_PORT_FIVE_DIR   = 6'h0D;
  localparam logic [5:0] OFF_PORT_ZERO_PINS  = 6'h10;
  localparam logic [5:0] OFF_PORT_GRID       = 6'h1D;

  // ==========================================================================
  // Reset values and fixed read values
  localparam logic [4:0] RST_PORT_ZERO  = 5'h1F;
  localparam logic [7:0] RST_PORT_ONE   = 8'h00;
  localparam logic [2:0] RST_PORT_TWO   = 3'h7;
  localparam logic [7:0] RST_PORT_FOUR  = 8'h00;
  localparam logic [3:0] RST_PORT_FIVE  = 4'h0;
  localparam logic [7:0] RST_PORT_VFT   = 8'h00;
  localparam logic [7:0] RST_DIR_ONE    = 8'h00;
  localparam logic [7:0] RST_DIR_FOUR   = 8'hFF;
  localparam logic [3:0] RST_DIR_FIVE   = 4'hF;
  localparam logic [7:0] RD_UNMAPPED    = 8'h00;
  localparam logic [7:0] RD_RESET       = 8'h00;

  // ==========================================================================
  // Instruction cycle: request taken, then sample_state, drive_state, answer
  localparam int PPS_ACCESS_CYCLES = 3;

  typedef enum logic [1:0] {
    PPS_IDLE,
    PPS_SAMPLE,
    PPS_DRIVE,
    PPS_DONE
  } pps_state_e;

  // How the instruction uses the port operand
  typedef enum logic [1:0] {
    PPS_KIND_PLAIN,
    PPS_KIND_LATCH,
    PPS_KIND_INDIRECT
  } pps_kind_e;

  typedef struct packed {
    logic [19:0] addr;
    logic        wr;
    pps_kind_e   kind;
    logic [7:0]  wdata;
  } pps_req_s;

  // All 68 port pins
  typedef struct packed {
    logic [4:0] p0;
    logic [7:0] p1;
    logic [2:0] p2;
    logic [7:0] p4;
    logic [3:0] p5;
    logic [7:0] p6;
    logic [7:0] p7;
    logic [7:0] p8;
    logic [7:0] p9;
    logic [7:0] pd;
  } pps_pins_s;

  localparam int PPS_PIN_W = $bits(pps_pins_s);

endpackage

// >>> core/pps_sync.sv
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
`default_nettype none
module pps_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// >>> core/pps_dbr_mem.sv
// Display data buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pps_dbr_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          mclk,
  input  wire logic          rd_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // No reset: contents are whatever software last stored
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;

endmodule
`default_nettype wire

// >>> core/pps_port_bank.sv
// Parallel port register bank: port latches, direction, pin sampling
//
// Overview of operation
// - Port and other special registers decode in addresses 00000h to 0003Fh.
// - Display data buffer sits at 00F00h to 00FFFh, apart from registers.
// - Each output port holds its value in a latch until rewritten.
// - Port reads sample pins in the first state, invisible outside.
// - Port writes update latch and pin in the second state.
// - Fixed ports return latch contents for read-modify-write style operands.
// - Indirect second operand of arithmetic returns the pin levels.
// - Port zero: latch register at 00h, read-only pin register at 10h.
// - Port zero has five open-drain bidirectional bits.
// - Reset sets all port zero latch bits to one.
// - Port levels hold through stop mode; software clears latches first.
// - Ten ports, 68 pins, widths five, eight, three, eight, four, eight.
// - Port one direction bit: zero input, one output; resets to zero.
`timescale 1ns/1ps
`default_nettype none
module pps_port_bank
  import pps_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst_n,
  input  wire logic      req_valid,
  output logic           req_ready,
  input  wire pps_req_s  req,
  output logic           rsp_valid,
  output logic [7:0]     rsp_data,
  input  wire logic      stop_mode,
  input  wire pps_pins_s pin_in,
  output pps_pins_s      pin_out,
  output pps_pins_s      pin_oe
);

  // ==========================================================================
  // Helper functions
  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Programmable ports: input bits show pins, output bits show the latch
  function automatic logic [7:0] prog_read(input logic [7:0] lat,
                                           input logic [7:0] pin,
                                           input logic [7:0] dir);
    return (lat & dir) | (pin & ~dir);
  endfunction

  // Fixed ports: the operand kind chooses latch or pins
  function automatic logic [7:0] fixed_read(input logic [7:0] lat,
                                            input logic [7:0] pin,
                                            input pps_kind_e  kind);
    logic [7:0] v;
    v = pin;
    if (kind == PPS_KIND_LATCH) begin
      v = lat;
    end
    return v;
  endfunction

  // ==========================================================================
  // Declarations
  pps_state_e state_r;
  pps_state_e state_nxt;
  pps_req_s   hold_r;
  pps_req_s   hold_nxt;
  logic       sfr_hit_r;
  logic       sfr_hit_nxt;
  logic       dbr_hit_r;
  logic       dbr_hit_nxt;
  pps_pins_s  snap_r;
  pps_pins_s  snap_nxt;
  pps_pins_s  lat_r;
  pps_pins_s  lat_nxt;
  logic [7:0] dir1_r;
  logic [7:0] dir1_nxt;
  logic [7:0] dir4_r;
  logic [7:0] dir4_nxt;
  logic [3:0] dir5_r;
  logic [3:0] dir5_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  pps_pins_s  pin_sync;
  logic [7:0] dbr_rdata;
  logic       dbr_rd_en;
  logic       dbr_wr_en;
  logic       wr_ok;
  logic [5:0] off;

  // ==========================================================================
  // Pin synchroniser and display buffer
  pps_sync #(
    .WIDTH (PPS_PIN_W)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  pps_dbr_mem #(
    .AW (PPS_DBR_AW),
    .DW (8)
  ) u_dbr (
    .mclk  (mclk),
    .rd_en (dbr_rd_en),
    .wr_en (dbr_wr_en),
    .addr  (hold_r.addr[PPS_DBR_AW-1:0]),
    .wdata (hold_r.wdata),
    .rdata (dbr_rdata)
  );

  // ==========================================================================
  // Access sequencer
  assign req_ready = (state_r == PPS_IDLE);
  assign rsp_valid = (state_r == PPS_DONE);
  assign off       = hold_r.addr[5:0];
  // Writes are frozen in stop mode so pins keep their levels
  assign wr_ok     = hold_r.wr && !stop_mode;

  always_comb begin
    state_nxt   = state_r;
    hold_nxt    = hold_r;
    sfr_hit_nxt = sfr_hit_r;
    dbr_hit_nxt = dbr_hit_r;
    case (state_r)
      PPS_IDLE: begin
        if (req_valid) begin
          hold_nxt    = req;
          sfr_hit_nxt = in_range(req.addr, PPS_SFR_FIRST, PPS_SFR_LAST);
          dbr_hit_nxt = in_range(req.addr, PPS_DBR_FIRST, PPS_DBR_LAST);
          state_nxt   = PPS_SAMPLE;
        end
      end
      PPS_SAMPLE: state_nxt = PPS_DRIVE;
      PPS_DRIVE:  state_nxt = PPS_DONE;
      PPS_DONE:   state_nxt = PPS_IDLE;
      default:    state_nxt = PPS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r   <= PPS_IDLE;
      hold_r    <= '0;
      sfr_hit_r <= 1'b0;
      dbr_hit_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      hold_r    <= hold_nxt;
      sfr_hit_r <= sfr_hit_nxt;
      dbr_hit_r <= dbr_hit_nxt;
    end
  end

  // ==========================================================================
  // Pin snapshot, taken only in sample_state
  always_comb begin
    snap_nxt = snap_r;
    if (state_r == PPS_SAMPLE) begin
      snap_nxt = pin_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      snap_r <= '0;
    end else begin
      snap_r <= snap_nxt;
    end
  end

  // Buffer read issued in sample_state, write in drive_state
  assign dbr_rd_en = (state_r == PPS_SAMPLE) && dbr_hit_r && !hold_r.wr;
  assign dbr_wr_en = (state_r == PPS_DRIVE) && dbr_hit_r && wr_ok;

  // ==========================================================================
  // Read data, formed in drive_state from the snapshot, latches, directions or buffer
  always_comb begin
    rdata_nxt = rdata_r;
    if ((state_r == PPS_DRIVE) && !hold_r.wr) begin
      rdata_nxt = RD_UNMAPPED;
      if (dbr_hit_r) begin
        rdata_nxt = dbr_rdata;
      end else if (sfr_hit_r) begin
        case (off)
          OFF_PORT_ZERO_LATCH: rdata_nxt = {3'h0, lat_r.p0};
          OFF_PORT_ZERO_PINS:  rdata_nxt = {3'h0, snap_r.p0};
          OFF_PORT_ONE:   rdata_nxt = prog_read(lat_r.p1, snap_r.p1, dir1_r);
          OFF_PORT_TWO: begin
            rdata_nxt = fixed_read({5'h00, lat_r.p2}, {5'h00, snap_r.p2},
                                   hold_r.kind);
          end
          OFF_PORT_FOUR:  rdata_nxt = prog_read(lat_r.p4, snap_r.p4, dir4_r);
          OFF_PORT_FIVE: begin
            rdata_nxt = prog_read({4'h0, lat_r.p5}, {4'h0, snap_r.p5},
                                  {4'h0, dir5_r});
          end
          OFF_PORT_SIX:   rdata_nxt = fixed_read(lat_r.p6, snap_r.p6, hold_r.kind);
          OFF_PORT_SEVEN: rdata_nxt = fixed_read(lat_r.p7, snap_r.p7, hold_r.kind);
          OFF_PORT_EIGHT: rdata_nxt = fixed_read(lat_r.p8, snap_r.p8, hold_r.kind);
          OFF_PORT_NINE:  rdata_nxt = fixed_read(lat_r.p9, snap_r.p9, hold_r.kind);
          OFF_PORT_GRID:  rdata_nxt = fixed_read(lat_r.pd, snap_r.pd, hold_r.kind);
          OFF_PORT_ONE_DIR:  rdata_nxt = dir1_r;
          OFF_PORT_FOUR_DIR: rdata_nxt = dir4_r;
          OFF_PORT_FIVE_DIR: rdata_nxt = {4'h0, dir5_r};
          default:           rdata_nxt = RD_UNMAPPED;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= RD_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rsp_data = rdata_r;

  // ==========================================================================
  // Output latches and direction, written in drive_state
  // Latches keep their value between writes; nothing else touches them
  always_comb begin
    lat_nxt  = lat_r;
    dir1_nxt = dir1_r;
    dir4_nxt = dir4_r;
    dir5_nxt = dir5_r;
    if ((state_r == PPS_DRIVE) && sfr_hit_r && wr_ok) begin
      case (off)
        OFF_PORT_ZERO_LATCH: lat_nxt.p0 = hold_r.wdata[4:0];
        OFF_PORT_ONE:        lat_nxt.p1 = hold_r.wdata;
        OFF_PORT_TWO:        lat_nxt.p2 = hold_r.wdata[2:0];
        OFF_PORT_FOUR:       lat_nxt.p4 = hold_r.wdata;
        OFF_PORT_FIVE:       lat_nxt.p5 = hold_r.wdata[3:0];
        OFF_PORT_SIX:        lat_nxt.p6 = hold_r.wdata;
        OFF_PORT_SEVEN:      lat_nxt.p7 = hold_r.wdata;
        OFF_PORT_EIGHT:      lat_nxt.p8 = hold_r.wdata;
        OFF_PORT_NINE:       lat_nxt.p9 = hold_r.wdata;
        OFF_PORT_GRID:       lat_nxt.pd = hold_r.wdata;
        OFF_PORT_ONE_DIR:    dir1_nxt   = hold_r.wdata;
        OFF_PORT_FOUR_DIR:   dir4_nxt   = hold_r.wdata;
        OFF_PORT_FIVE_DIR:   dir5_nxt   = hold_r.wdata[3:0];
        // Pin register at 10h and all other offsets ignore writes
        default: begin
          lat_nxt  = lat_r;
          dir1_nxt = dir1_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lat_r.p0 <= RST_PORT_ZERO;
      lat_r.p1 <= RST_PORT_ONE;
      lat_r.p2 <= RST_PORT_TWO;
      lat_r.p4 <= RST_PORT_FOUR;
      lat_r.p5 <= RST_PORT_FIVE;
      lat_r.p6 <= RST_PORT_VFT;
      lat_r.p7 <= RST_PORT_VFT;
      lat_r.p8 <= RST_PORT_VFT;
      lat_r.p9 <= RST_PORT_VFT;
      lat_r.pd <= RST_PORT_VFT;
      dir1_r   <= RST_DIR_ONE;
      dir4_r   <= RST_DIR_FOUR;
      dir5_r   <= RST_DIR_FIVE;
    end else begin
      lat_r    <= lat_nxt;
      dir1_r   <= dir1_nxt;
      dir4_r   <= dir4_nxt;
      dir5_r   <= dir5_nxt;
    end
  end

  // ==========================================================================
  // Pin drivers for all 68 pins
  // Sink open drain (p0, p2): pull low while the latch holds zero
  // Tri-state (p1, p4, p5): drive the latch where direction is one
  // Source open drain (p6..p9, pd): pull high while the latch holds one
  always_comb begin
    pin_out    = lat_r;
    pin_out.p0 = 5'h00;
    pin_out.p2 = 3'h0;
    pin_oe.p0  = ~lat_r.p0;
    pin_oe.p1  = dir1_r;
    pin_oe.p2  = ~lat_r.p2;
    pin_oe.p4  = dir4_r;
    pin_oe.p5  = dir5_r;
    pin_oe.p6  = lat_r.p6;
    pin_oe.p7  = lat_r.p7;
    pin_oe.p8  = lat_r.p8;
    pin_oe.p9  = lat_r.p9;
    pin_oe.pd  = lat_r.pd;
  end

endmodule
`default_nettype wire

// >>> bench/pps_pins_model.sv
// Board model of the port pins: pull-ups, pull-downs, external drivers
`timescale 1ns/1ps
`default_nettype none
module pps_pins_model
  import pps_pkg::*;
(
  input  wire pps_pins_s pin_out,
  input  wire pps_pins_s pin_oe,
  input  wire pps_pins_s ext_val,
  input  wire pps_pins_s ext_en,
  output var pps_pins_s  pin_in
);
  // ==========================================================================
  // Wire resolution
  // Open drain with pull-up on p0 and p2; display ports pulled down
  localparam pps_pins_s PULL_UP = '{p0: '1, p2: '1, default: '0};
  localparam pps_pins_s NO_PULL = '{p1: '1, p4: '1, p5: '1, default: '0};
  // Floating tri-state lines (p1, p4, p5) show the inverse of the latch, so a stale value cannot pass
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (PULL_UP | (NO_PULL & ~pin_out)));
endmodule
`default_nettype wire

// >>> bench/pps_port_bank_checker.sv
// Concurrent assertions on the port bank's ports
`timescale 1ns/1ps
`default_nettype none
module pps_port_bank_checker
  import pps_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire pps_req_s   req,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       stop_mode,
  input wire pps_pins_s  pin_in,
  input wire pps_pins_s  pin_out,
  input wire pps_pins_s  pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic rd;
  assign take = req_valid && req_ready;
  assign rd   = take && !req.wr;
  // ==========================================================================
  // Access timing
  AST_ANSWER: assert property (take |-> ##3 rsp_valid)
    else $error("answer late");
  AST_BUSY: assert property (take |=> !req_ready [*3])
    else $error("request taken while busy");
  AST_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  // ==========================================================================
  // Latches and pins
  AST_OPEN_DRAIN: assert property (pin_out.p0 == 5'h00 && pin_out.p2 == 3'h0)
    else $error("open drain drives high");
  AST_RESET: assert property ($rose(rst_n) |-> pin_oe.p0 == 5'h00
    && pin_oe.p1 == 8'h00 && pin_out.p1 == 8'h00)
    else $error("reset values wrong");
  AST_HOLD: assert property (!rsp_valid |-> $stable(pin_out) && $stable(pin_oe))
    else $error("pins moved without a write");
  AST_FREEZE: assert property ($past(stop_mode) |-> $stable(pin_out))
    else $error("pins moved in stop mode");
  AST_WR_P0: assert property (take && req.wr && req.addr == 20'h00000 ##2 !stop_mode
    |=> pin_oe.p0 == ~$past(req.wdata[4:0], 3))
    else $error("port zero write lost");
  AST_RD_P0: assert property (rd && req.addr == 20'h00000
    |-> ##3 rsp_data == {3'h0, ~pin_oe.p0})
    else $error("port zero latch read wrong");
  AST_RD_DIR: assert property (rd && req.addr == 20'h0000B |-> ##3 rsp_data == pin_oe.p1)
    else $error("direction read wrong");
  COV_WR: cover property (take && req.wr && req.addr == 20'h00000);
  COV_PINS: cover property (rd && req.addr == 20'h00010);
  COV_STOP: cover property (take && req.wr && stop_mode);
endmodule
`default_nettype wire

// >>> bench/pps_port_bank_tb_top.sv
// Testbench top for the parallel port register bank
`timescale 1ns/1ps
`default_nettype none
module pps_port_bank_tb_top
  import pps_pkg::*;
;
  logic       mclk;
  logic       rst_n;
  logic       req_valid;
  logic       req_ready;
  pps_req_s   req;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       stop_mode;
  pps_pins_s  pin_in, pin_out, pin_oe, ext_val, ext_en;
  logic [7:0] rd;
  int         errors;
  int         n_checks;

  pps_port_bank dut (.mclk, .rst_n, .req_valid, .req_ready, .req, .rsp_valid,
                     .rsp_data, .stop_mode, .pin_in, .pin_out, .pin_oe);
  pps_pins_model board (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after a rising edge; returns just after one
  task automatic acc(input logic [19:0] a, input logic w, input pps_kind_e k,
                     input logic [7:0] d);
    int i;
    req = '{a, w, k, d};
    req_valid = 1'b1;
    i = 0;
    while (req_ready !== 1'b1 && i < 8) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (i == 8) begin
      errors++;
      test_done();
    end
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    i = 0;
    while (rsp_valid !== 1'b1 && i < 8) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (i == 8) begin
      errors++;
      test_done();
    end
    rd = rsp_data;
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    acc(a, 1'b1, PPS_KIND_PLAIN, d);
  endtask

  task automatic rdchk(input logic [19:0] a, input logic [7:0] e,
                       input pps_kind_e k = PPS_KIND_PLAIN);
    acc(a, 1'b0, k, 8'h00);
    chk(rd, e);
  endtask

  // Pins pass two synchroniser flops before a read can see them
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk({3'h0, pin_oe.p0}, 8'h00);
    rdchk(20'h00000, 8'h1F);
    rdchk(20'h0000B, 8'h00);
    rdchk(20'h0000C, 8'hFF);
    rdchk(20'h0000D, 8'h0F);
  endtask

  task automatic t_port_zero();
    wr(20'h00000, 8'h15);
    chk({3'h0, pin_oe.p0}, 8'h0A);
    settle();
    rdchk(20'h00010, 8'h15);
    ext_en.p0 = 5'h01;
    settle();
    rdchk(20'h00010, 8'h14);
    rdchk(20'h00000, 8'h15);
  endtask

  task automatic t_port_one();
    wr(20'h00001, 8'hA5);
    wr(20'h0000B, 8'h0F);
    chk(pin_oe.p1, 8'h0F);
    chk(pin_out.p1, 8'hA5);
    ext_en.p1 = 8'hF0;
    ext_val.p1 = 8'h3C;
    settle();
    rdchk(20'h00001, 8'h35);
    wr(20'h00004, 8'h3C);
    rdchk(20'h00004, 8'h3C);
  endtask

  task automatic t_kinds();
    wr(20'h00006, 8'h5A);
    ext_en.p6 = 8'hA5;
    ext_val.p6 = 8'hA5;
    settle();
    rdchk(20'h00006, 8'h5A, PPS_KIND_LATCH);
    rdchk(20'h00006, 8'hFF);
    rdchk(20'h00006, 8'hFF, PPS_KIND_INDIRECT);
    wr(20'h0001D, 8'h81);
    rdchk(20'h0001D, 8'h81, PPS_KIND_LATCH);
  endtask

  task automatic t_stop();
    stop_mode = 1'b1;
    wr(20'h00001, 8'h00);
    chk(pin_out.p1, 8'hA5);
    stop_mode = 1'b0;
    wr(20'h00001, 8'h00);
    chk(pin_out.p1, 8'h00);
  endtask

  task automatic t_odd();
    // Reserved offsets are never touched; only the not-accessible ones
    wr(20'h00012, 8'hFF);
    rdchk(20'h00014, 8'h00);
    rdchk(20'h00012, 8'h00);
    wr(20'h00010, 8'h00);
    rdchk(20'h00000, 8'h15);
    wr(20'h00000, 8'hFF);
    rdchk(20'h00000, 8'h1F);
    wr(20'h00002, 8'hFF);
    rdchk(20'h00002, 8'h07, PPS_KIND_LATCH);
    rdchk(20'h00040, 8'h00);
    wr(20'h00F37, 8'hC3);
    wr(20'h00FFF, 8'h3C);
    rdchk(20'h00F37, 8'hC3);
    rdchk(20'h00FFF, 8'h3C);
    wr(20'h00000, 8'h1E);
    chk({3'h0, pin_oe.p0}, 8'h01);
  endtask

  initial begin
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    stop_mode = 1'b0;
    ext_val = '0;
    ext_en = '0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_port_zero();
    t_port_one();
    t_kinds();
    t_stop();
    t_odd();
    test_done();
  end
endmodule

bind pps_port_bank pps_port_bank_checker chk_i (.mclk(mclk), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .stop_mode(stop_mode), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe));
`default_nettype wire
